// *** dac_i2c_cfg.svh ***
`ifndef DAC_I2C_CFG_SVH
`define DAC_I2C_CFG_SVH

// ----------------------------------------
// address decode
// ----------------------------------------
`define BCAST_ADDR 7'h48
`define MCODE_PFX 5'h01
`define ADDR_HI_FLOAT 5'h03
`define ADDR_HI_GND 5'h02
`define ADDR_HI_SUPPLY 5'h13
`define ADDR_LO_FLOAT 2'h0
`define ADDR_LO_GND 2'h1
`define ADDR_LO_SUPPLY 2'h2

// ----------------------------------------
// conversion word
// ----------------------------------------
`define WORD_W 16
`define WORD_RST 16'h0000
`define WORD_MSB 15
`define ZERO_LEAD 2'h0
`define BIT_LAST 3'h7
`define FIFO_DEPTH_DEF 8

// ----------------------------------------
// spike suppression figures
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define SPIKE_FS_NS 50
`define SPIKE_HS_NS 10
`define SPIKE_FS_CYC (((`SPIKE_FS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define SPIKE_HS_CYC (((`SPIKE_HS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

// *** dac_i2c_pkg.sv ***
package dac_i2c_pkg;

	// ----------------------------------------
	// three-level strap as seen by the pad
	// ----------------------------------------
	typedef enum logic [1:0] {
		STRAP_GND,
		STRAP_FLOAT,
		STRAP_SUPPLY
	} strap_t;

	// ----------------------------------------
	// conversion register layout, msb first
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] zero_lead;
		logic powerdown_mode_hi;
		logic powerdown_mode_lo;
		logic [11:0] code;
	} dac_word_t;

endpackage

// *** reg_fifo.sv ***
`timescale 1ns/10ps

module reg_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	// depth must be a power of two: wrap bit tells full from empty
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_ptr_q;
	logic [AW:0] rd_ptr_q;
	logic full;
	logic push;
	logic pop;

	// ----------------------------------------
	// flags
	// ----------------------------------------
	assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	assign in_ready_o = ~full;
	assign out_valid_o = (wr_ptr_q != rd_ptr_q);
	assign push = in_valid_i & ~full;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];

	// storage, no reset: only valid slots are ever read
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
		end
	end

	// pointers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end
endmodule

// *** dac_register_i2c_slave.sv ***
`timescale 1ns/10ps
`include "dac_i2c_cfg.svh"


module dac_register_i2c_slave #(
	parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF,
	parameter bit DUAL_SELECT = 1'b0
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire dac_i2c_pkg::strap_t addr_select_low_i,
	input wire dac_i2c_pkg::strap_t addr_select_high_i,
	input wire logic dac_ready_i,
	output dac_i2c_pkg::dac_word_t dac_word_o,
	output logic dac_update_o,
	output logic hs_mode_o,
	output logic addr_locked_o
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_BYTE,
		ST_WR_ACK,
		ST_RD_BYTE,
		ST_RD_ACK,
		ST_IGNORE
	} link_state_t;

	// ----------------------------------------
	// strap decode
	// ----------------------------------------
	function automatic logic [6:0] decode_addr(
		input dac_i2c_pkg::strap_t hi,
		input dac_i2c_pkg::strap_t lo,
		input logic dual
	);
		logic [4:0] pfx;
		logic [1:0] sfx;
		pfx = `ADDR_HI_FLOAT;
		sfx = `ADDR_LO_FLOAT;
		if (dual) begin
			case (hi)
				dac_i2c_pkg::STRAP_GND: pfx = `ADDR_HI_GND;
				dac_i2c_pkg::STRAP_SUPPLY: pfx = `ADDR_HI_SUPPLY;
				default: pfx = `ADDR_HI_FLOAT;
			endcase
		end
		case (lo)
			dac_i2c_pkg::STRAP_GND: sfx = `ADDR_LO_GND;
			dac_i2c_pkg::STRAP_SUPPLY: sfx = `ADDR_LO_SUPPLY;
			default: sfx = `ADDR_LO_FLOAT;
		endcase
		return {pfx, sfx};
	endfunction

	// ----------------------------------------
	// link domain declarations
	// ----------------------------------------
	logic link_rst_meta_q;
	logic link_rst_q;
	logic sda_pos_q;
	logic stop_tgl_q;
	logic stop_ack_q;
	logic stop_pend;
	logic start_c;
	link_state_t state_q;
	link_state_t state_d;
	logic [2:0] bit_cnt_q;
	logic byte_done;
	logic [7:0] rx_q;
	logic [7:0] rx_byte;
	logic [7:0] hi_byte_q;
	logic rw_q;
	logic lo_phase_q;
	logic [`WORD_W-1:0] tx_q;
	logic sda_drv_q;
	logic sda_drv_d;
	logic hs_q;
	logic lock_q;
	logic [6:0] lock_addr_q;
	logic [6:0] own_addr;
	logic mcode_c;
	logic own_hit_c;
	logic bc_hit_c;
	logic addr_ok_c;
	logic commit_c;
	logic busy_c;
	dac_i2c_pkg::dac_word_t reg_q;
	logic wr_tgl_q;
	logic ack_s1_q;
	logic ack_s2_q;
	dac_i2c_pkg::strap_t strap_lo_s1_q;
	dac_i2c_pkg::strap_t strap_lo_s2_q;
	dac_i2c_pkg::strap_t strap_hi_s1_q;
	dac_i2c_pkg::strap_t strap_hi_s2_q;

	// ----------------------------------------
	// system domain declarations
	// ----------------------------------------
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic ack_tgl_q;
	logic pend_c;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [`WORD_W-1:0] fifo_out_data;
	logic hs_s1_q;
	logic hs_s2_q;
	logic lock_s1_q;
	logic lock_s2_q;
	dac_i2c_pkg::dac_word_t dac_word_q;
	logic dac_update_q;

	// ----------------------------------------
	// link reset and input sampling
	// ----------------------------------------
	// reset reaches the scl domain only while scl toggles
	always_ff @(posedge scl_i) begin
		link_rst_meta_q <= srst_i;
		link_rst_q <= link_rst_meta_q;
	end

	// data bit is valid while scl is high
	always_ff @(posedge scl_i) begin
		sda_pos_q <= sda_i;
	end

	// straps are slow pads, two stages before the decoder
	always_ff @(posedge scl_i) begin
		strap_lo_s1_q <= addr_select_low_i;
		strap_lo_s2_q <= strap_lo_s1_q;
		strap_hi_s1_q <= addr_select_high_i;
		strap_hi_s2_q <= strap_hi_s1_q;
	end

	// ack toggle from the system side
	always_ff @(posedge scl_i) begin
		ack_s1_q <= ack_tgl_q;
		ack_s2_q <= ack_s1_q;
	end

	// ----------------------------------------
	// stop detection
	// ----------------------------------------
	// scl stands still after a stop, so the sda edge itself marks it
	always_ff @(posedge sda_i) begin
		if (link_rst_q) begin
			stop_tgl_q <= 1'b0;
		end else if (scl_i) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	assign stop_pend = stop_tgl_q ^ stop_ack_q;
	// sda high at scl rise (or a stop pending), low at scl fall: only a mid-high edge
	// counts, so a short sda spike while scl is low cannot fake a start
	assign start_c = ~sda_i & (sda_pos_q | stop_pend);

	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			stop_ack_q <= 1'b0;
		end else if (start_c | stop_pend) begin
			stop_ack_q <= stop_tgl_q;
		end
	end

	// ----------------------------------------
	// byte decode
	// ----------------------------------------
	assign byte_done = (bit_cnt_q == `BIT_LAST);
	assign rx_byte = {rx_q[6:0], sda_pos_q};
	assign own_addr = lock_q ? lock_addr_q : decode_addr(strap_hi_s2_q, strap_lo_s2_q, DUAL_SELECT);
	assign mcode_c = (rx_byte[7:3] == `MCODE_PFX);
	assign own_hit_c = (rx_byte[7:1] == own_addr);
	assign bc_hit_c = (rx_byte[7:1] == `BCAST_ADDR) & ~rx_byte[0];
	assign addr_ok_c = ~mcode_c & (own_hit_c | bc_hit_c);
	assign busy_c = wr_tgl_q ^ ack_s2_q;
	assign commit_c = (state_q == ST_WR_BYTE) & byte_done & lo_phase_q & ~busy_c;

	// ----------------------------------------
	// link state and sda drive
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		sda_drv_d = 1'b0;
		unique case (state_q)
			ST_IDLE, ST_IGNORE: begin
				state_d = state_q;
			end
			ST_ADDR: begin
				if (byte_done) begin
					state_d = addr_ok_c ? ST_ADDR_ACK : ST_IGNORE;
					sda_drv_d = addr_ok_c;
				end
			end
			ST_ADDR_ACK: begin
				state_d = rw_q ? ST_RD_BYTE : ST_WR_BYTE;
				sda_drv_d = rw_q & ~reg_q[`WORD_MSB];
			end
			ST_WR_BYTE: begin
				if (byte_done) begin
					// a word still in flight to the fifo refuses the pair
					state_d = (lo_phase_q & busy_c) ? ST_IGNORE : ST_WR_ACK;
					sda_drv_d = ~(lo_phase_q & busy_c);
				end
			end
			ST_WR_ACK: begin
				state_d = ST_WR_BYTE;
			end
			ST_RD_BYTE: begin
				if (byte_done) begin
					state_d = ST_RD_ACK;
				end else begin
					sda_drv_d = ~tx_q[`WORD_MSB-1];
				end
			end
			ST_RD_ACK: begin
				// controller ack after the upper byte asks for the lower
				if (~sda_pos_q & ~lo_phase_q) begin
					state_d = ST_RD_BYTE;
					sda_drv_d = ~tx_q[`WORD_MSB];
				end else begin
					state_d = ST_IGNORE;
				end
			end
		endcase
	end

	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			state_q <= ST_IDLE;
		end else if (start_c) begin
			state_q <= ST_ADDR;
		end else if (stop_pend) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// sda changes only after scl falls
	always_ff @(negedge scl_i) begin
		if (link_rst_q | start_c | stop_pend) begin
			sda_drv_q <= 1'b0;
		end else begin
			sda_drv_q <= sda_drv_d;
		end
	end

	// open drain: data is always low, the enable does the work
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~sda_drv_q;

	// ----------------------------------------
	// bit counting and shifting
	// ----------------------------------------
	always_ff @(negedge scl_i) begin
		if (link_rst_q | start_c) begin
			bit_cnt_q <= '0;
		end else if ((state_q == ST_ADDR) || (state_q == ST_WR_BYTE) || (state_q == ST_RD_BYTE)) begin
			bit_cnt_q <= bit_cnt_q + 1'b1;
		end else begin
			bit_cnt_q <= '0;
		end
	end

	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			rx_q <= '0;
		end else if ((state_q == ST_ADDR) || (state_q == ST_WR_BYTE)) begin
			rx_q <= rx_byte;
		end
	end

	// read/write bit and byte phase
	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			rw_q <= 1'b0;
			lo_phase_q <= 1'b0;
		end else if (start_c) begin
			lo_phase_q <= 1'b0;
		end else if ((state_q == ST_ADDR) && byte_done) begin
			rw_q <= rx_byte[0];
			lo_phase_q <= 1'b0;
		end else if (state_q == ST_WR_ACK) begin
			lo_phase_q <= ~lo_phase_q;
		end else if (state_q == ST_RD_ACK) begin
			lo_phase_q <= 1'b1;
		end
	end

	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			hi_byte_q <= '0;
		end else if ((state_q == ST_WR_BYTE) && byte_done && ~lo_phase_q) begin
			hi_byte_q <= rx_byte;
		end
	end

	// read shifter: loaded at the address ack, one bit per scl fall
	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			tx_q <= '0;
		end else if ((state_q == ST_ADDR_ACK) && rw_q) begin
			tx_q <= reg_q;
		end else if (state_q == ST_RD_BYTE) begin
			tx_q <= {tx_q[`WORD_MSB-1:0], 1'b0};
		end
	end

	// ----------------------------------------
	// speed mode and address lock
	// ----------------------------------------
	always_ff @(negedge scl_i) begin
		if (link_rst_q || stop_pend) begin
			hs_q <= 1'b0;
		end else if ((state_q == ST_ADDR) && byte_done && mcode_c) begin
			hs_q <= 1'b1;
		end
	end

	// broadcast never locks; only the own address does
	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			lock_q <= 1'b0;
			lock_addr_q <= '0;
		end else if ((state_q == ST_ADDR) && byte_done && ~mcode_c && own_hit_c && ~lock_q) begin
			lock_q <= 1'b1;
			lock_addr_q <= own_addr;
		end
	end

	// ----------------------------------------
	// conversion register
	// ----------------------------------------
	// also the crossing data: it holds still until the ack returns
	always_ff @(negedge scl_i) begin
		if (link_rst_q) begin
			reg_q <= `WORD_RST;
			wr_tgl_q <= 1'b0;
		end else if (commit_c) begin
			reg_q <= {`ZERO_LEAD, hi_byte_q[5:0], rx_byte};
			wr_tgl_q <= ~wr_tgl_q;
		end
	end

	// ----------------------------------------
	// crossing into the system clock
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
		end else begin
			tgl_s1_q <= wr_tgl_q;
			tgl_s2_q <= tgl_s1_q;
		end
	end

	assign pend_c = tgl_s2_q ^ ack_tgl_q;

	// ack returns only once the fifo took the word
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ack_tgl_q <= 1'b0;
		end else if (pend_c && fifo_in_ready) begin
			ack_tgl_q <= tgl_s2_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hs_s1_q <= 1'b0;
			hs_s2_q <= 1'b0;
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
		end else begin
			hs_s1_q <= hs_q;
			hs_s2_q <= hs_s1_q;
			lock_s1_q <= lock_q;
			lock_s2_q <= lock_s1_q;
		end
	end

	reg_fifo #(
		.WIDTH(`WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_word_fifo (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_valid_i(pend_c),
		.in_ready_o(fifo_in_ready),
		.in_data_i(reg_q),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(dac_ready_i),
		.out_data_o(fifo_out_data)
	);

	// ----------------------------------------
	// converter side
	// ----------------------------------------
	// zero until the first word arrives through the fifo
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dac_word_q <= `WORD_RST;
			dac_update_q <= 1'b0;
		end else begin
			dac_update_q <= fifo_out_valid & dac_ready_i;
			if (fifo_out_valid && dac_ready_i) begin
				dac_word_q <= fifo_out_data;
			end
		end
	end

	assign dac_word_o = dac_word_q;
	assign dac_update_o = dac_update_q;
	assign hs_mode_o = hs_s2_q;
	assign addr_locked_o = lock_s2_q;
endmodule

// *** dac_register_i2c_slave_assertions.sv ***
`timescale 1ns/10ps

module dac_i2c_checker (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire dac_i2c_pkg::strap_t addr_select_low_i,
	input wire dac_i2c_pkg::strap_t addr_select_high_i,
	input wire logic dac_ready_i,
	input wire dac_i2c_pkg::dac_word_t dac_word_o,
	input wire logic dac_update_o,
	input wire logic hs_mode_o,
	input wire logic addr_locked_o
);
	// ----
	// word side
	// ----
	property p_zero_lead;
		@(posedge clk_i) disable iff (srst_i) dac_word_o.zero_lead == 2'h0;
	endproperty
	a_zero_lead: assert property (p_zero_lead)
		else $error("leading word bits not zero");
	// a load without the converter taking it would lose a word
	property p_update_ready;
		@(posedge clk_i) disable iff (srst_i) dac_update_o |-> $past(dac_ready_i);
	endproperty
	a_update_ready: assert property (p_update_ready)
		else $error("word loaded while converter not ready");
	property p_word_hold;
		@(posedge clk_i) disable iff (srst_i) !dac_update_o |-> $stable(dac_word_o);
	endproperty
	a_word_hold: assert property (p_word_hold)
		else $error("word changed without update");
	property p_reset_clear;
		@(posedge clk_i) disable iff (srst_i)
			$fell(srst_i) |-> dac_word_o == 16'h0000 && !addr_locked_o;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("word or lock not cleared by reset");
	property p_reset_idle;
		@(posedge clk_i) disable iff (srst_i) $fell(srst_i) |-> sda_oe_n_o && !hs_mode_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("bus not idle after reset");
	property p_lock_sticky;
		@(posedge clk_i) disable iff (srst_i) addr_locked_o |=> addr_locked_o;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("address lock dropped");
	// ----
	// bus side
	// ----
	property p_drive_low;
		@(posedge clk_i) disable iff (srst_i) sda_o == 1'b0;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("data line driven high");
	// ack plus a full zero byte is the longest pull; then the controller answers
	sequence s_pulled_long;
		!sda_oe_n_o [*8] ##1 !sda_oe_n_o;
	endsequence
	property p_release_for_ack;
		@(posedge scl_i) disable iff (srst_i) s_pulled_long |=> sda_oe_n_o;
	endproperty
	a_release_for_ack: assert property (p_release_for_ack)
		else $error("data line held past a byte");
endmodule

bind dac_register_i2c_slave dac_i2c_checker u_dac_i2c_checker (.clk_i(clk_i), .srst_i(srst_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.addr_select_low_i(addr_select_low_i), .addr_select_high_i(addr_select_high_i),
	.dac_ready_i(dac_ready_i), .dac_word_o(dac_word_o), .dac_update_o(dac_update_o),
	.hs_mode_o(hs_mode_o), .addr_locked_o(addr_locked_o));

// *** i2c_ctrl_model.sv ***
`timescale 1ns/10ps

module i2c_ctrl_model (
	input wire logic sda_i,
	output logic scl_oe_n_o,
	output logic sda_oe_n_o
);
	// quarter of the 48 ns link period
	localparam time QTR = 12;

	// both lines released at time zero
	initial begin
		scl_oe_n_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	// free clocks only around reset, link logic needs edges to clear
	task automatic clocks(input int n);
		repeat (n) begin
			#(2*QTR) scl_oe_n_o = 1'b0;
			#(2*QTR) scl_oe_n_o = 1'b1;
		end
	endtask
	// start or repeated start, sda falls with scl high
	task automatic start();
		sda_oe_n_o = 1'b1;
		#QTR scl_oe_n_o = 1'b1;
		#QTR sda_oe_n_o = 1'b0;
		#QTR scl_oe_n_o = 1'b0;
		#QTR;
	endtask
	// stop, sda rises with scl high; clock then stands still
	task automatic stop();
		sda_oe_n_o = 1'b0;
		#QTR scl_oe_n_o = 1'b1;
		#QTR sda_oe_n_o = 1'b1;
		#(2*QTR);
	endtask
	// byte plus ninth bit, a one only releases the line
	task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
		output logic ack_seen);
		logic [8:0] sh;
		sh = {tx, ack_bit};
		for (int i = 8; i >= 0; i--) begin
			sda_oe_n_o = sh[i];
			#QTR scl_oe_n_o = 1'b1;
			#QTR sh[i] = sda_i;
			#QTR scl_oe_n_o = 1'b0;
			#QTR;
		end
		rx = sh[8:1];
		ack_seen = sh[0];
	endtask
endmodule

// *** dac_register_i2c_slave_test.sv ***
`timescale 1ns/10ps

module dac_register_i2c_slave_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ready = 1'b1;
	dac_i2c_pkg::strap_t strap_lo = dac_i2c_pkg::STRAP_GND;
	wire scl;
	wire sda;
	wire ctrl_scl_oe_n;
	wire ctrl_sda_oe_n;
	logic dut_sda;
	logic dut_oe_n;
	dac_i2c_pkg::dac_word_t dac_word;
	logic dac_update;
	logic hs_mode;
	logic locked;
	int mismatches = 0;
	int check_count = 0;
	int update_count = 0;

	always #50 clk = ~clk;
	// pull-ups on both lines, the controller may pull either low, the slave only sda
	assign scl = ctrl_scl_oe_n;
	assign sda = ctrl_sda_oe_n & (dut_oe_n | dut_sda);
	// counted on the falling edge so the count is settled at the rising one
	always @(negedge clk) if (dac_update === 1'b1) update_count++;

	dac_register_i2c_slave u_dac_register_i2c_slave (.clk_i(clk), .srst_i(srst), .scl_i(scl),
		.sda_i(sda), .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n), .addr_select_low_i(strap_lo),
		.addr_select_high_i(dac_i2c_pkg::STRAP_FLOAT), .dac_ready_i(ready),
		.dac_word_o(dac_word), .dac_update_o(dac_update), .hs_mode_o(hs_mode),
		.addr_locked_o(locked));
	i2c_ctrl_model u_i2c_ctrl_model (.sda_i(sda), .scl_oe_n_o(ctrl_scl_oe_n),
		.sda_oe_n_o(ctrl_sda_oe_n));

	// ----
	// helpers
	// ----
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_updates(input int n);
		int i;
		i = 0;
		while (update_count < n && i < 200) begin
			@(posedge clk);
			i++;
		end
		check("update count", 16'(update_count), 16'(n));
		if (update_count < n) tally_and_finish();
	endtask
	task automatic wait_hs(input logic exp);
		int i;
		i = 0;
		while (hs_mode !== exp && i < 20) begin
			@(posedge clk);
			i++;
		end
		check("speed flag", 16'(hs_mode), 16'(exp));
		if (hs_mode !== exp) tally_and_finish();
	endtask
	task automatic addr(input logic [6:0] a, input logic rw, output logic ack);
		logic [7:0] rx;
		u_i2c_ctrl_model.start();
		u_i2c_ctrl_model.xfer({a, rw}, 1'b1, rx, ack);
	endtask
	task automatic wr_pair(input logic [15:0] w, output logic [1:0] acks);
		logic [7:0] rx;
		u_i2c_ctrl_model.xfer(w[15:8], 1'b1, rx, acks[1]);
		u_i2c_ctrl_model.xfer(w[7:0], 1'b1, rx, acks[0]);
	endtask
	// controller acks the upper byte, nacks the lower
	task automatic rd_word(input logic [6:0] a, output logic ack, output logic [15:0] w);
		logic n;
		addr(a, 1'b1, ack);
		u_i2c_ctrl_model.xfer(8'hff, 1'b0, w[15:8], n);
		u_i2c_ctrl_model.xfer(8'hff, 1'b1, w[7:0], n);
		u_i2c_ctrl_model.stop();
	endtask

	// ----
	// scenarios
	// ----
	task automatic test_strap_lock();
		logic a;
		logic [1:0] p;
		logic [15:0] w;
		addr(7'h0c, 1'b0, a);
		check("float address", 16'(a), 16'h0001);
		wr_pair(16'h0fff, p);
		check("ignored bytes", 16'(p), 16'h0003);
		u_i2c_ctrl_model.stop();
		check("lock before match", 16'(locked), 16'h0000);
		addr(7'h0d, 1'b0, a);
		wr_pair(16'hc0a5, p);
		check("write acks", 16'({a, p}), 16'h0000);
		wait_updates(1);
		check("word applied", dac_word, 16'h00a5);
		@(posedge clk) strap_lo <= dac_i2c_pkg::STRAP_SUPPLY;
		rd_word(7'h0d, a, w);
		check("read ack", 16'(a), 16'h0000);
		check("read back", w, 16'h00a5);
		check("lock after match", 16'(locked), 16'h0001);
		addr(7'h0e, 1'b0, a);
		u_i2c_ctrl_model.stop();
		check("strap change ignored", 16'(a), 16'h0001);
		$display("test strap_lock done");
	endtask
	// converter stalls until the buffer is full and the link refuses
	task automatic test_fifo_stall();
		logic a;
		logic [1:0] p;
		logic [15:0] w;
		@(posedge clk) ready <= 1'b0;
		addr(7'h0d, 1'b0, a);
		for (int k = 1; k <= 10; k++) begin
			wr_pair({8'hf0 | 8'(k), 8'(k)}, p);
			check("stalled acks", 16'(p), k == 10 ? 16'h0001 : 16'h0000);
		end
		u_i2c_ctrl_model.stop();
		check("stalled updates", 16'(update_count), 16'h0001);
		@(posedge clk) ready <= 1'b1;
		wait_updates(10);
		check("last buffered word", dac_word, 16'h3909);
		rd_word(7'h0d, a, w);
		check("mode bits kept", w, 16'h3909);
		check("refused word dropped", 16'(update_count), 16'h000a);
		$display("test fifo_stall done");
	endtask
	task automatic test_broadcast();
		logic a;
		logic [1:0] p;
		addr(7'h48, 1'b0, a);
		wr_pair(16'h1234, p);
		u_i2c_ctrl_model.stop();
		check("broadcast acks", 16'({a, p}), 16'h0000);
		wait_updates(11);
		check("broadcast word", dac_word, 16'h1234);
		addr(7'h48, 1'b1, a);
		u_i2c_ctrl_model.stop();
		check("broadcast read", 16'(a), 16'h0001);
		$display("test broadcast done");
	endtask
	task automatic test_high_speed();
		logic a;
		logic [1:0] p;
		logic [7:0] rx;
		for (int x = 0; x < 8; x++) begin
			u_i2c_ctrl_model.start();
			u_i2c_ctrl_model.xfer(8'h08 | 8'(x), 1'b1, rx, a);
			check("master code", 16'(a), 16'h0001);
			if (x < 7) u_i2c_ctrl_model.stop();
		end
		wait_hs(1'b1);
		addr(7'h0d, 1'b0, a);
		wr_pair(16'h0155, p);
		check("fast write acks", 16'({a, p}), 16'h0000);
		wait_updates(12);
		check("fast word", dac_word, 16'h0155);
		check("still fast", 16'(hs_mode), 16'h0001);
		u_i2c_ctrl_model.stop();
		// scl stands still after the stop: the flag drops at the next plain start
		addr(7'h0d, 1'b0, a);
		wait_hs(1'b0);
		check("plain start after stop", 16'(a), 16'h0000);
		u_i2c_ctrl_model.stop();
		$display("test high_speed done");
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		fork
			begin
				repeat (6) @(posedge clk);
				srst <= 1'b0;
			end
			begin
				u_i2c_ctrl_model.clocks(4);
				// an sda rise inside reset gives the sda-clocked stop flop a known value
				u_i2c_ctrl_model.stop();
				u_i2c_ctrl_model.clocks(9);
			end
		join
		u_i2c_ctrl_model.clocks(3);
		check("word at reset", dac_word, 16'h0000);
		check("idle flags", 16'({hs_mode, locked}), 16'h0000);
		test_strap_lock();
		test_fifo_stall();
		test_broadcast();
		test_high_speed();
		tally_and_finish();
	end
endmodule
